// [verilog/bus_buffer_regs.vh]
`ifndef BUS_BUFFER_REGS_VH
`define BUS_BUFFER_REGS_VH
// Behaviour
// - Divide the crystal clock by twelve to make the timer base clock.
// - Assert power unit select low on I/O access to either power-unit port.
// - With hold acknowledge low, latch CPU address onto peripheral address on strobe.
// - Byte DMA: latch upper address from peripheral data, drive onto address bits 8-15.
// - Word DMA: latch upper address from peripheral data, drive its bits 0-6 onto address bits 9-15.
// - Memory latch enable opens CPU/memory data latches; read direction sets direction.
// - Conversion steering follows the two code bits only while codes are valid.
// - Steer 16-bit CPU accesses to 8-bit devices, also for DMA and master cycles; the code steers only the CPU data path, not the system bus.
// - System direction high drives memory to system; low drives system to memory.
// - Peripheral direction high drives system to peripheral; low the reverse.
// - On RAM writes generate even parity per byte onto the parity lines.
// - On memory reads check even parity per byte; flag error low on odd parity.
// - Read direction low moves memory to CPU; high moves CPU to memory.
// - High system direction bit steers high byte, low bit steers low byte; the code lets the low bit select the whole word driven to memory.

// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
`define CLOCK_DIVIDE 4'hC
`define CLOCK_DIVIDE_HALF 4'h6
`define POWER_PORT_LOW 16'h0022
`define POWER_PORT_HIGH 16'h0023
`define CODE_WRITE 2'h0
`define CODE_READ 2'h1
`define CODE_HI_WRITE 2'h2
`define CODE_HI_READ 2'h3
`endif

// [verilog/bus_buffer.v]
`include "bus_buffer_regs.vh"

module bus_buffer (
  input wire clock_in,
  input wire rst_in,
  input wire crystal_tick_in,
  input wire io_cycle_in,
  input wire [15:0] cpu_addr_in,
  input wire cpu_address_latch_strobe_in,
  input wire hold_acknowledge_in,
  input wire dma_byte_upper_strobe_in,
  input wire dma_word_upper_strobe_in,
  input wire dma_byte_address_enable_n_in,
  input wire dma_word_address_enable_n_in,
  input wire memory_latch_enable_in,
  input wire memory_read_direction_n_in,
  input wire conversion_code_valid_n_in,
  input wire conversion_code_low_in,
  input wire conversion_code_high_in,
  input wire system_bus_dir_low_in,
  input wire system_bus_dir_high_in,
  input wire peripheral_bus_dir_n_in,
  input wire ram_write_in,
  input wire mem_read_in,
  input wire high_byte_enable_n_in,
  input wire [15:0] cpu_data_in,
  input wire [15:0] memory_data_bus_in,
  input wire [15:0] system_data_bus_in,
  input wire [7:0] peripheral_data_bus_in,
  input wire mem_parity_low_in,
  input wire mem_parity_high_in,
  output reg timer_base_clock_out,
  output reg power_unit_select_n_out,
  output reg [15:0] peripheral_address_bus_out,
  output reg [15:0] cpu_data_out,
  output reg cpu_data_oe_n_out,
  output reg [15:0] memory_data_bus_out,
  output reg memory_data_oe_n_out,
  output reg [15:0] system_data_bus_out,
  output reg [1:0] system_data_oe_n_out,
  output reg [7:0] peripheral_data_bus_out,
  output reg peripheral_data_oe_n_out,
  output reg mem_parity_low_out,
  output reg mem_parity_high_out,
  output reg mem_parity_oe_n_out,
  output reg parity_fault_n_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function even_parity;
    input [7:0] b;
    begin
      even_parity = ^b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Timer base divider
  // ----------------------------------------------------------------
  // The crystal rate arrives as a one-cycle tick; the output toggles every six ticks.
  reg [3:0] div_q;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 4'h0;
      timer_base_clock_out <= 1'b0;
    end else if (crystal_tick_in) begin
      if (div_q == `CLOCK_DIVIDE_HALF - 4'h1) begin
        div_q <= 4'h0;
        timer_base_clock_out <= ~timer_base_clock_out;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address path
  // ----------------------------------------------------------------
  reg [15:0] cpu_addr_q;
  reg [7:0] dma_byte_q;
  reg [7:0] dma_word_q;
  reg [15:0] cpu_addr_d;
  reg [7:0] dma_byte_d;
  reg [7:0] dma_word_d;
  reg [15:0] addr_d;

  // Next latch contents are used for the bus as well, so a strobe reaches it at the following edge.
  always @* begin
    cpu_addr_d = cpu_addr_q;
    if (cpu_address_latch_strobe_in && !hold_acknowledge_in) begin
      cpu_addr_d = cpu_addr_in;
    end
  end

  always @* begin
    dma_byte_d = dma_byte_q;
    if (dma_byte_upper_strobe_in) begin
      dma_byte_d = peripheral_data_bus_in;
    end
  end

  always @* begin
    dma_word_d = dma_word_q;
    if (dma_word_upper_strobe_in) begin
      dma_word_d = peripheral_data_bus_in;
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_addr_q <= 16'h0000;
      dma_byte_q <= 8'h00;
      dma_word_q <= 8'h00;
    end else begin
      cpu_addr_q <= cpu_addr_d;
      dma_byte_q <= dma_byte_d;
      dma_word_q <= dma_word_d;
    end
  end

  // The bus has sixteen lines, so the top bit of a word page has no line to land on.
  always @* begin
    addr_d = cpu_addr_d;
    if (!dma_byte_address_enable_n_in) begin
      addr_d = {dma_byte_d, cpu_addr_d[7:0]};
    end else if (!dma_word_address_enable_n_in) begin
      addr_d = {dma_word_d[6:0], cpu_addr_d[8:0]};
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      peripheral_address_bus_out <= 16'h0000;
    end else begin
      peripheral_address_bus_out <= addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Power unit port decode
  // ----------------------------------------------------------------
  // Address lines carry bit n at index n; bit 0 is the peripheral address lsb.
  wire power_port_hit;
  assign power_port_hit = io_cycle_in && (cpu_addr_in == `POWER_PORT_LOW || cpu_addr_in == `POWER_PORT_HIGH);

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      power_unit_select_n_out <= 1'b1;
    end else begin
      power_unit_select_n_out <= ~power_port_hit;
    end
  end

  // ----------------------------------------------------------------
  // Data steering
  // ----------------------------------------------------------------
  reg [15:0] md_latch_q;
  reg [15:0] cpu_latch_q;
  reg [15:0] md_view;
  reg [15:0] md_d;
  reg [15:0] cpu_d;
  wire [1:0] code;
  wire steer;
  assign code = {conversion_code_high_in, conversion_code_low_in};
  assign steer = !conversion_code_valid_n_in;

  // An open read latch is transparent, so read data reaches the CPU one edge after it appears.
  always @* begin
    md_view = md_latch_q;
    if (memory_latch_enable_in && !memory_read_direction_n_in) begin
      md_view = memory_data_bus_in;
    end
  end

  // Byte swaps move the odd byte across lanes for 8-bit partners.
  always @* begin
    md_d = cpu_data_in;
    cpu_d = md_view;
    if (steer) begin
      case (code)
        `CODE_WRITE: begin
          md_d = cpu_data_in;
        end
        `CODE_READ: begin
          cpu_d = md_view;
        end
        `CODE_HI_WRITE: begin
          md_d = {cpu_data_in[15:8], cpu_data_in[15:8]};
        end
        `CODE_HI_READ: begin
          cpu_d = {md_view[7:0], md_view[7:0]};
        end
        default: begin
          md_d = cpu_data_in;
          cpu_d = md_view;
        end
      endcase
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      md_latch_q <= 16'h0000;
      cpu_latch_q <= 16'h0000;
    end else begin
      if (memory_latch_enable_in) begin
        if (!memory_read_direction_n_in) begin
          md_latch_q <= memory_data_bus_in;
        end else begin
          cpu_latch_q <= md_d;
        end
      end
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_data_out <= 16'h0000;
      cpu_data_oe_n_out <= 1'b1;
    end else begin
      cpu_data_out <= cpu_d;
      cpu_data_oe_n_out <= memory_read_direction_n_in;
    end
  end

  // ----------------------------------------------------------------
  // Memory, system and peripheral buffers
  // ----------------------------------------------------------------
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      memory_data_bus_out <= 16'h0000;
      memory_data_oe_n_out <= 1'b1;
    end else begin
      memory_data_bus_out <= system_bus_dir_low_in ? cpu_latch_q : system_data_bus_in;
      memory_data_oe_n_out <= ~(memory_read_direction_n_in || ~system_bus_dir_low_in);
    end
  end

  // The low system lane is fed from memory when its direction bit is high, else from the peripheral bus.
  wire [7:0] sd_low_d;
  assign sd_low_d = system_bus_dir_low_in ? memory_data_bus_in[7:0] : peripheral_data_bus_in;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      system_data_bus_out <= 16'h0000;
      system_data_oe_n_out <= 2'h3;
    end else begin
      system_data_bus_out <= {memory_data_bus_in[15:8], sd_low_d};
      system_data_oe_n_out <= {~system_bus_dir_high_in, ~(system_bus_dir_low_in | ~peripheral_bus_dir_n_in)};
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      peripheral_data_bus_out <= 8'h00;
      peripheral_data_oe_n_out <= 1'b1;
    end else begin
      peripheral_data_bus_out <= system_data_bus_in[7:0];
      peripheral_data_oe_n_out <= ~peripheral_bus_dir_n_in;
    end
  end

  // ----------------------------------------------------------------
  // Parity
  // ----------------------------------------------------------------
  // Parity follows the CPU latch word, so data and check bits land together only while the low system direction bit drives that word to memory.
  wire fault;
  assign fault = mem_read_in && (
    (!cpu_addr_in[0] && (even_parity(memory_data_bus_in[7:0]) != mem_parity_low_in)) ||
    (!high_byte_enable_n_in && (even_parity(memory_data_bus_in[15:8]) != mem_parity_high_in)));

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mem_parity_low_out <= 1'b0;
      mem_parity_high_out <= 1'b0;
      mem_parity_oe_n_out <= 1'b1;
    end else begin
      mem_parity_low_out <= even_parity(cpu_latch_q[7:0]);
      mem_parity_high_out <= even_parity(cpu_latch_q[15:8]);
      mem_parity_oe_n_out <= ~ram_write_in;
    end
  end

  // Not sticky: the controller samples the flag in the cycle it stands.
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      parity_fault_n_out <= 1'b1;
    end else begin
      parity_fault_n_out <= ~(fault && !ram_write_in);
    end
  end

endmodule // bus_buffer

// [verif/bus_buffer_assertions.sv]
module bus_buffer_checker (
  input logic clock_in, rst_in, io_cycle_in, cpu_address_latch_strobe_in, hold_acknowledge_in, ram_write_in,
  input logic mem_read_in, high_byte_enable_n_in, mem_parity_low_in, mem_parity_high_in, system_bus_dir_low_in,
  input logic system_bus_dir_high_in, power_unit_select_n_out, mem_parity_low_out, parity_fault_n_out,
  input logic peripheral_bus_dir_n_in, mem_parity_high_out,
  input logic [15:0] memory_data_bus_out,
  input logic [1:0] system_data_oe_n_out,
  input logic [15:0] cpu_addr_in, cpu_data_in, memory_data_bus_in, peripheral_address_bus_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire hit = io_cycle_in && cpu_addr_in[15:1] == 15'h0011;
  sequence s_bad;
    mem_read_in && !ram_write_in && (!cpu_addr_in[0] && ^{memory_data_bus_in[7:0], mem_parity_low_in}
      || !high_byte_enable_n_in && ^{memory_data_bus_in[15:8], mem_parity_high_in});
  endsequence
  property p_sel_on; hit |=> !power_unit_select_n_out; endproperty
  a_sel_on: assert property (p_sel_on) else $error("no select");
  property p_sel_off; !hit |=> power_unit_select_n_out; endproperty
  a_sel_off: assert property (p_sel_off) else $error("bad select");
  property p_flt_on; s_bad |=> !parity_fault_n_out; endproperty
  a_flt_on: assert property (p_flt_on) else $error("no fault");
  property p_flt_off; !mem_read_in || ram_write_in |=> parity_fault_n_out; endproperty
  a_flt_off: assert property (p_flt_off) else $error("bad fault");
  property p_xa; cpu_address_latch_strobe_in && !hold_acknowledge_in
    |=> peripheral_address_bus_out == $past(cpu_addr_in); endproperty
  a_xa: assert property (p_xa) else $error("address");
  property p_par; ram_write_in && system_bus_dir_low_in |=> mem_parity_low_out == ^memory_data_bus_out[7:0]
    && mem_parity_high_out == ^memory_data_bus_out[15:8]; endproperty
  a_par: assert property (p_par) else $error("parity");
  property p_sd_hi; system_bus_dir_high_in |=> !system_data_oe_n_out[1]; endproperty
  a_sd_hi: assert property (p_sd_hi) else $error("high lane");
  property p_sd_lo; !system_bus_dir_low_in && peripheral_bus_dir_n_in |=> system_data_oe_n_out[0]; endproperty
  a_sd_lo: assert property (p_sd_lo) else $error("low lane");
  property p_sd_lo_on; system_bus_dir_low_in |=> !system_data_oe_n_out[0]; endproperty
  a_sd_lo_on: assert property (p_sd_lo_on) else $error("low lane idle");
endmodule // bus_buffer_checker
bind bus_buffer bus_buffer_checker bus_buffer_checker_i (.*);

// [verif/ram_model.sv]
module ram_model (
  input wire logic clock_in, store_n_in, read_in,
  input wire logic [1:0] flip_in, par_in,
  input wire logic [15:0] wr_data_in,
  output logic [15:0] data_out,
  output logic [1:0] par_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] data_q;
  logic [1:0] par_q;
  always @(posedge clock_in) if (!store_n_in) begin
    data_q <= wr_data_in;
    par_q <= par_in;
  end
  // A released bus shows the inverse, so stale data never passes for a read.
  assign data_out = read_in ? data_q : ~data_q;
  assign par_out = read_in ? par_q ^ flip_in : ~par_q;
endmodule // ram_model

// [verif/tb_address_data_buffer_parity.sv]
module tb_address_data_buffer_parity;
  timeunit 1ns;
  timeprecision 100ps;
  bit clock_in, crystal_tick_in, io_cycle_in, cpu_address_latch_strobe_in, hold_acknowledge_in, ram_write_in;
  bit dma_byte_upper_strobe_in, dma_word_upper_strobe_in, memory_latch_enable_in, conversion_code_low_in;
  bit conversion_code_high_in, system_bus_dir_low_in, system_bus_dir_high_in, peripheral_bus_dir_n_in;
  bit mem_read_in, memory_read_direction_n_in;
  bit [15:0] cpu_addr_in, cpu_data_in, system_data_bus_in;
  bit [7:0] peripheral_data_bus_in;
  bit [1:0] flip;
  logic rst_in = 1, dma_byte_address_enable_n_in = 1, dma_word_address_enable_n_in = 1;
  logic conversion_code_valid_n_in = 1, high_byte_enable_n_in = 1;
  wire [15:0] memory_data_bus_in, peripheral_address_bus_out, cpu_data_out, memory_data_bus_out, system_data_bus_out;
  wire [7:0] peripheral_data_bus_out;
  wire [1:0] system_data_oe_n_out;
  wire mem_parity_low_in, mem_parity_high_in, timer_base_clock_out, power_unit_select_n_out, cpu_data_oe_n_out;
  wire memory_data_oe_n_out, peripheral_data_oe_n_out, mem_parity_low_out, mem_parity_high_out;
  wire mem_parity_oe_n_out, parity_fault_n_out;
  int error_cnt, check_count;
  bus_buffer bus_buffer_i (.*);
  ram_model ram_model_i (.clock_in, .store_n_in(mem_parity_oe_n_out), .read_in(mem_read_in), .flip_in(flip),
    .par_in({mem_parity_high_out, mem_parity_low_out}), .wr_data_in(memory_data_bus_out),
    .data_out(memory_data_bus_in), .par_out({mem_parity_high_in, mem_parity_low_in}));
  always #2 clock_in = ~clock_in;
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_power;
    for (int i = 0; i < 16; i++) begin
      io_cycle_in = i[3];
      cpu_addr_in = 16'h001E + i[2:0];
      step(1);
      chk(power_unit_select_n_out, !(i[3] && cpu_addr_in[15:1] == 15'h0011));
    end
    io_cycle_in = 0;
    $display("power test done");
  endtask
  task automatic t_addr;
    cpu_addr_in = 16'h1234;
    cpu_address_latch_strobe_in = 1;
    step(1);
    hold_acknowledge_in = 1;
    cpu_addr_in = 16'h0F0F;
    step(2);
    chk(peripheral_address_bus_out, 16'h1234);
    peripheral_data_bus_in = 8'hA5;
    dma_byte_upper_strobe_in = 1;
    dma_byte_address_enable_n_in = 0;
    step(2);
    chk(peripheral_address_bus_out[15:8], 8'hA5);
    {dma_byte_upper_strobe_in, dma_byte_address_enable_n_in, peripheral_data_bus_in} = 10'h13C;
    dma_word_upper_strobe_in = 1;
    dma_word_address_enable_n_in = 0;
    step(2);
    chk(peripheral_address_bus_out[15:9], 7'h3C);
    {hold_acknowledge_in, cpu_address_latch_strobe_in, dma_word_upper_strobe_in} = 3'h0;
    dma_word_address_enable_n_in = 1;
    $display("address test done");
  endtask
  task automatic t_parity;
    {cpu_addr_in, cpu_data_in} = 32'h0000_B762;
    {memory_latch_enable_in, memory_read_direction_n_in, ram_write_in} = 3'h7;
    system_bus_dir_low_in = 1;
    step(2);
    chk(mem_parity_oe_n_out, 1'b0);
    chk({mem_parity_high_out, mem_parity_low_out}, 2'h1);
    chk(memory_data_oe_n_out, 1'b0);
    {memory_read_direction_n_in, ram_write_in, high_byte_enable_n_in, mem_read_in} = 4'h1;
    step(2);
    chk(parity_fault_n_out, 1'b1);
    chk(cpu_data_out, 16'hB762);
    chk(cpu_data_oe_n_out, 1'b0);
    for (int i = 1; i < 8; i++) begin
      {high_byte_enable_n_in, flip} = i[2:0];
      step(2);
      chk(parity_fault_n_out, !(i[0] || i[1] && !i[2]));
    end
    {ram_write_in, flip} = 3'h7;
    step(2);
    chk(parity_fault_n_out, 1'b1);
    {ram_write_in, flip, mem_read_in, memory_latch_enable_in} = 5'h0;
    $display("parity test done");
  endtask
  task automatic t_dirs;
    system_data_bus_in = 16'h5AC3;
    for (int i = 0; i < 8; i++) begin
      {system_bus_dir_high_in, system_bus_dir_low_in, peripheral_bus_dir_n_in} = i[2:0];
      step(1);
      chk(system_data_oe_n_out, {!i[2], !(i[1] || !i[0])});
      chk(system_data_bus_out, i[1] ? 16'h489D : 16'h483C);
      chk(memory_data_bus_out, i[1] ? 16'hB762 : 16'h5AC3);
      chk(peripheral_data_oe_n_out, !i[0]);
      if (i[0]) chk(peripheral_data_bus_out, 8'hC3);
    end
    $display("direction test done");
  endtask
  task automatic t_steer;
    {conversion_code_valid_n_in, conversion_code_high_in, conversion_code_low_in} = 3'h3;
    {memory_latch_enable_in, memory_read_direction_n_in, mem_read_in, system_bus_dir_low_in} = 4'hB;
    step(1);
    chk(cpu_data_out, 16'h6262);
    {conversion_code_low_in, memory_read_direction_n_in, mem_read_in} = 3'h2;
    step(2);
    chk(memory_data_bus_out, 16'hB7B7);
    {conversion_code_valid_n_in, conversion_code_high_in, memory_latch_enable_in} = 3'h4;
    $display("steering test done");
  endtask
  task automatic t_timer;
    int k;
    logic last;
    last = timer_base_clock_out;
    // Two spare cycles leave room for pipeline delay of the divider without a seventh tick.
    repeat (146) begin
      crystal_tick_in = ~crystal_tick_in;
      step(1);
      k += timer_base_clock_out !== last;
      last = timer_base_clock_out;
    end
    chk(k, 12);
    $display("timer test done");
  endtask
  initial begin
    step(3);
    rst_in = 0;
    chk(power_unit_select_n_out, 1'b1);
    chk(parity_fault_n_out, 1'b1);
    t_power;
    t_addr;
    t_parity;
    t_dirs;
    t_steer;
    t_timer;
    test_done;
  end
endmodule // tb_address_data_buffer_parity
